// ### system_trim_config_regs.v
// Configuration, status and trim register bank for the system resources
// Behaviour
// - External clock bit picks pin clock over oscillator
// - Watchdog source one forces internal slow oscillator
// - Watchdog source zero follows system slow clock
// - Double speed disable zero runs fast source
// - Pump disable bit one turns pump off
// - Power-on trip field picks one of four
// - Throttle enable lets low voltage reset speed
// - Three-bit field sets detect and pump levels
// - Read-only comparator status, one means below trip
// - Precision status valid only at top level
// - Eight capacitor switch bits, one removes segment
// - Four-bit fields select each current DAC control
// - Write-only main oscillator trim, centre at 0x80
// - Bias trim field selects oscillator bias
// - Boot loads factory trims into trim fields
// - Ground bypass bit connects pin capacitor
// - Duty field sets sleep on-off ratio
// - Current trim zero largest, three smallest
// - Flash bank bit acts only in supervisory mode
`default_nettype none
`include "system_trim_consts.vh"
module system_trim_config_regs (
	// Clock and raw reset
	input wire clk_sys_in,
	input wire rstn_in,
	// Register port, same clock as the bank
	input wire [`ADDR_W-1:0] addr_in,
	input wire [`DATA_W-1:0] wdata_in,
	input wire wr_in,
	input wire rd_in,
	output reg [`DATA_W-1:0] rdata_out,
	// Factory trim load from the boot sequencer
	input wire boot_load_in,
	input wire [`DATA_W-1:0] boot_mosc_trim_in,
	input wire [`DATA_W-1:0] boot_losc_trim_in,
	input wire [`DATA_W-1:0] boot_bgap_trim_in,
	input wire [`DATA_W-1:0] boot_xosc_trim_in,
	// Analog comparators, asynchronous to this clock
	input wire pump_below_in,
	input wire lvd_below_in,
	input wire precision_power_on_state_below_in,
	input wire precision_power_on_state_reset_disabled_in,
	// Current DAC control sources from the analog array
	input wire [3:0] decimator_input_in,
	input wire [3:0] accumulator_compare_in,
	input wire [1:0] ramp_compare_output_in,
	// High while supervisory code runs
	input wire supervisory_mode_in,
	// Clock tree controls
	output reg external_clock_select_out,
	output reg watchdog_clock_internal_out,
	output reg sleep_extend_out,
	output reg fast_clock_enable_out,
	output reg sysclk_force_on_out,
	// Supply monitor controls
	output reg pump_enable_out,
	output reg [1:0] power_on_trip_level_out,
	output reg cpu_speed_reset_out,
	output reg [2:0] low_voltage_level_out,
	output reg precision_power_on_state_status_valid_out,
	// Analog trims and selections
	output reg [`DATA_W-1:0] adc0_cap_trim_value_out,
	output reg [`DATA_W-1:0] adc1_cap_trim_value_out,
	output reg [1:0] idac_on_out,
	output reg [`DATA_W-1:0] main_oscillator_trim_out,
	output reg [5:0] low_speed_oscillator_trim_out,
	output reg analog_ground_bypass_out,
	output reg [5:0] bandgap_trim_out,
	output reg [1:0] sleep_duty_cycle_out,
	output reg [1:0] oscillator_current_trim_out,
	output reg flash_bank_out
);
	// Reset synchroniser and two-stage samplers for analog comparators
	reg rst_meta;
	reg rst_sync;
	reg [2:0] cmp_meta;
	reg [2:0] cmp_sync;
	reg [3:0] dec_meta;
	reg [3:0] dec_sync;
	reg [3:0] acc_meta;
	reg [3:0] acc_sync;
	reg [1:0] ramp_meta;
	reg [1:0] ramp_sync;
	reg [3:0] misc_meta;
	reg [3:0] misc_sync;
	// Register storage
	reg [`DATA_W-1:0] osc_ctrl2;
	reg [`DATA_W-1:0] vmon_ctrl;
	reg [`DATA_W-1:0] adc0_trim;
	reg [`DATA_W-1:0] adc1_trim;
	reg [`DATA_W-1:0] idac_sel;
	reg [`DATA_W-1:0] mosc_trim;
	reg [`DATA_W-1:0] losc_trim;
	reg [`DATA_W-1:0] bgap_trim;
	reg [`DATA_W-1:0] xosc_trim;
	reg [`DATA_W-1:0] mosc_cur;
	reg [`DATA_W-1:0] flash_bank;
	reg [`DATA_W-1:0] next_rdata;
	// Boot strobe edge so the factory load happens once per request
	reg boot_prev;
	wire boot_pulse;
	assign boot_pulse = misc_sync[0] & ~boot_prev;

	// Pick a current DAC control signal from a four-bit source code
	// Used for both DACs, so one copy of the decode serves them
	// Reserved codes give off rather than a floating choice
	function idac_pick;
		input [3:0] code;
		input [3:0] dec;
		input [3:0] acc;
		input [1:0] ramp;
		begin
			if (code == `IDAC_ALWAYS_ON)
				idac_pick = 1'b1;
			else if (code[3:2] == `IDAC_DEC_BASE)
				idac_pick = dec[code[1:0]];
			else if (code[3:2] == `IDAC_ACC_BASE)
				idac_pick = acc[code[1:0]];
			else if (code == `IDAC_RAMP0)
				idac_pick = ramp[0];
			else if (code == `IDAC_RAMP1)
				idac_pick = ramp[1];
			else
				idac_pick = 1'b0;
		end
	endfunction

	// Reset release through two flops
	// Assertion stays asynchronous; only the release is retimed
	always @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end

	// Asynchronous inputs pass two flops before use
	// Status therefore lags the comparator by two cycles
	// The spare misc bit is tied low to keep the bundle even
	always @(posedge clk_sys_in or negedge rst_sync) begin
		if (!rst_sync) begin
			cmp_meta <= 3'h0;
			cmp_sync <= 3'h0;
			dec_meta <= 4'h0;
			dec_sync <= 4'h0;
			acc_meta <= 4'h0;
			acc_sync <= 4'h0;
			ramp_meta <= 2'h0;
			ramp_sync <= 2'h0;
			misc_meta <= 4'h0;
			misc_sync <= 4'h0;
			boot_prev <= 1'b0;
		end else begin
			cmp_meta <= {pump_below_in, lvd_below_in, precision_power_on_state_below_in};
			cmp_sync <= cmp_meta;
			dec_meta <= decimator_input_in;
			dec_sync <= dec_meta;
			acc_meta <= accumulator_compare_in;
			acc_sync <= acc_meta;
			ramp_meta <= ramp_compare_output_in;
			ramp_sync <= ramp_meta;
			misc_meta <= {1'b0, supervisory_mode_in, precision_power_on_state_reset_disabled_in, boot_load_in};
			misc_sync <= misc_meta;
			boot_prev <= misc_sync[0];
		end
	end

	// Register writes; masks drop reserved bits so stray ones are harmless
	// A write in the boot-strobe cycle is lost; boot runs once, so software rarely meets it
	always @(posedge clk_sys_in or negedge rst_sync) begin
		if (!rst_sync) begin
			// Power-on contents of the bank
			osc_ctrl2 <= `RST_ZERO;
			vmon_ctrl <= `RST_ZERO;
			// Zero trims switch every capacitor segment in
			adc0_trim <= `RST_ZERO;
			adc1_trim <= `RST_ZERO;
			// Both current DACs start always on
			idac_sel <= `RST_ZERO;
			// Lowest code until the factory value arrives
			mosc_trim <= `RST_MOSC;
			losc_trim <= `RST_ZERO;
			// Bandgap starts at trim 0x18 until boot overwrites it
			bgap_trim <= `RST_BGAP;
			xosc_trim <= `RST_ZERO;
			// Largest oscillator current after reset
			mosc_cur <= `RST_ZERO;
			flash_bank <= `RST_ZERO;
		end else if (boot_pulse) begin
			// Factory trims win over a coincident write
			mosc_trim <= boot_mosc_trim_in;
			losc_trim <= boot_losc_trim_in & `MASK_LOSC;
			// Bypass bit is a user choice, so the factory load leaves it alone
			bgap_trim <= (bgap_trim & `MASK_BGAP_KEEP) | (boot_bgap_trim_in & `MASK_BGAP_FACT);
			// Only the duty-cycle field exists in the crystal trim
			xosc_trim <= boot_xosc_trim_in & `MASK_XOSC;
		end else if (wr_in) begin
			// Address decode; unmapped offsets and the status offset change nothing
			// Clock source and watchdog control
			if (addr_in == `OFF_OSC_CTRL2)
				osc_ctrl2 <= wdata_in & `MASK_OSC_CTRL2;
			// Supply monitor levels, throttle and pump
			else if (addr_in == `OFF_VMON_CTRL)
				vmon_ctrl <= wdata_in & `MASK_VMON_CTRL;
			// Column capacitor trims, all eight bits live
			else if (addr_in == `OFF_ADC0_TRIM)
				adc0_trim <= wdata_in;
			else if (addr_in == `OFF_ADC1_TRIM)
				adc1_trim <= wdata_in;
			// Current DAC source codes, one per nibble
			else if (addr_in == `OFF_IDAC_SEL)
				idac_sel <= wdata_in;
			// Main oscillator trim, write-only
			else if (addr_in == `OFF_MOSC_TRIM)
				mosc_trim <= wdata_in;
			// Slow oscillator bias and frequency
			else if (addr_in == `OFF_LOSC_TRIM)
				losc_trim <= wdata_in & `MASK_LOSC;
			// Bandgap trim and ground bypass
			else if (addr_in == `OFF_BGAP_TRIM)
				bgap_trim <= wdata_in & `MASK_BGAP;
			// Sleep duty cycle
			else if (addr_in == `OFF_XOSC_TRIM)
				xosc_trim <= wdata_in & `MASK_XOSC;
			// Oscillator current trim
			else if (addr_in == `OFF_MOSC_CUR)
				mosc_cur <= wdata_in & `MASK_MOSC_CUR;
			// Flash bank choice
			else if (addr_in == `OFF_FLASH_BANK)
				flash_bank <= wdata_in & `MASK_FLASH;
		end
	end

	// Read mux; main oscillator trim is write-only and reads zero
	// Unmapped offsets fall to the zero default
	always @* begin
		next_rdata = `RST_ZERO;
		// Clock source control
		if (addr_in == `OFF_OSC_CTRL2)
			next_rdata = osc_ctrl2;
		// Supply monitor control
		else if (addr_in == `OFF_VMON_CTRL)
			next_rdata = vmon_ctrl;
		// Synchronised comparators, upper bits zero
		else if (addr_in == `OFF_VMON_STAT)
			next_rdata = {5'h00, cmp_sync};
		// Column capacitor trims
		else if (addr_in == `OFF_ADC0_TRIM)
			next_rdata = adc0_trim;
		else if (addr_in == `OFF_ADC1_TRIM)
			next_rdata = adc1_trim;
		// Current DAC source codes
		else if (addr_in == `OFF_IDAC_SEL)
			next_rdata = idac_sel;
		// Oscillator and bandgap trims
		else if (addr_in == `OFF_LOSC_TRIM)
			next_rdata = losc_trim;
		else if (addr_in == `OFF_BGAP_TRIM)
			next_rdata = bgap_trim;
		else if (addr_in == `OFF_XOSC_TRIM)
			next_rdata = xosc_trim;
		else if (addr_in == `OFF_MOSC_CUR)
			next_rdata = mosc_cur;
		// Flash bank choice
		else if (addr_in == `OFF_FLASH_BANK)
			next_rdata = flash_bank;
	end

	// Read data stand only in the cycle after the strobe
	// Returning zero otherwise lets a shared bus simply OR the slaves
	always @(posedge clk_sys_in or negedge rst_sync) begin
		if (!rst_sync)
			rdata_out <= `RST_ZERO;
		else if (rd_in)
			rdata_out <= next_rdata;
		else
			rdata_out <= `RST_ZERO;
	end

	// Control outputs registered from the bank, one cycle behind storage
	// The extra cycle buys glitch-free levels at the analog controls
	always @(posedge clk_sys_in or negedge rst_sync) begin
		if (!rst_sync) begin
			// Reset levels match the reset contents of the bank
			external_clock_select_out <= 1'b0;
			watchdog_clock_internal_out <= 1'b0;
			sleep_extend_out <= 1'b0;
			fast_clock_enable_out <= 1'b1;
			sysclk_force_on_out <= 1'b1;
			pump_enable_out <= 1'b1;
			power_on_trip_level_out <= 2'h0;
			cpu_speed_reset_out <= 1'b0;
			low_voltage_level_out <= 3'h0;
			precision_power_on_state_status_valid_out <= 1'b0;
			adc0_cap_trim_value_out <= `RST_ZERO;
			adc1_cap_trim_value_out <= `RST_ZERO;
			idac_on_out <= `RST_IDAC_ON;
			main_oscillator_trim_out <= `RST_MOSC;
			low_speed_oscillator_trim_out <= 6'h00;
			analog_ground_bypass_out <= 1'b0;
			bandgap_trim_out <= `RST_BGAP_OUT;
			sleep_duty_cycle_out <= 2'h0;
			oscillator_current_trim_out <= 2'h0;
			flash_bank_out <= 1'b0;
		end else begin
			// Clock tree controls
			external_clock_select_out <= osc_ctrl2[`BIT_EXT_CLK];
			// One forces internal slow clock, zero follows system choice
			watchdog_clock_internal_out <= osc_ctrl2[`BIT_WDT_SRC];
			sleep_extend_out <= osc_ctrl2[`BIT_SLP_EXT];
			fast_clock_enable_out <= ~osc_ctrl2[`BIT_DBL_DIS];
			sysclk_force_on_out <= ~osc_ctrl2[`BIT_DBL_DIS];
			// Supply monitor controls
			pump_enable_out <= ~vmon_ctrl[`BIT_PUMP_DIS];
			power_on_trip_level_out <= vmon_ctrl[`POR_HI:`POR_LO];
			// Throttle only while enabled and comparator active
			cpu_speed_reset_out <= vmon_ctrl[`BIT_THROTTLE] & cmp_sync[`BIT_ST_LVD];
			low_voltage_level_out <= vmon_ctrl[`LVL_HI:`LVL_LO];
			precision_power_on_state_status_valid_out <= misc_sync[1] & (vmon_ctrl[`POR_HI:`POR_LO] == `POR_CODE_RSVD);
			// Capacitor trims pass straight through
			adc0_cap_trim_value_out <= adc0_trim;
			adc1_cap_trim_value_out <= adc1_trim;
			// One on/off pick per DAC from its own nibble
			idac_on_out[0] <= idac_pick(idac_sel[3:0], dec_sync, acc_sync, ramp_sync);
			idac_on_out[1] <= idac_pick(idac_sel[7:4], dec_sync, acc_sync, ramp_sync);
			// Oscillator and bandgap trims
			main_oscillator_trim_out <= mosc_trim;
			low_speed_oscillator_trim_out <= losc_trim[`TRIM_HI:0];
			analog_ground_bypass_out <= bgap_trim[`BIT_AGND_BYP];
			bandgap_trim_out <= bgap_trim[`TRIM_HI:0];
			// Sleep duty cycle and oscillator current
			sleep_duty_cycle_out <= xosc_trim[`DUTY_HI:`DUTY_LO];
			oscillator_current_trim_out <= mosc_cur[1:0];
			// Bank choice only reaches the flash in supervisory mode
			flash_bank_out <= flash_bank[0] & misc_sync[2];
		end
	end
endmodule
`default_nettype wire

// ### system_trim_consts.vh
// Register offsets, field positions, reset values and codes of the system trim register bank
`ifndef SYSTEM_TRIM_CONSTS_VH
`define SYSTEM_TRIM_CONSTS_VH
`define ADDR_W 8
`define DATA_W 8
// Register byte offsets
`define OFF_OSC_CTRL2 8'h00_E2
`define OFF_VMON_CTRL 8'h00_E3
`define OFF_VMON_STAT 8'h00_E4
`define OFF_ADC0_TRIM 8'h00_E5
`define OFF_ADC1_TRIM 8'h00_E6
`define OFF_IDAC_SEL 8'h00_E7
`define OFF_MOSC_TRIM 8'h00_E8
`define OFF_LOSC_TRIM 8'h00_E9
`define OFF_BGAP_TRIM 8'h00_EA
`define OFF_XOSC_TRIM 8'h00_EB
`define OFF_MOSC_CUR 8'h00_EF
`define OFF_FLASH_BANK 8'h00_FA
// Writable bit masks; reserved bits read zero
`define MASK_OSC_CTRL2 8'h00_1D
`define MASK_VMON_CTRL 8'h00_BF
`define MASK_FULL 8'h00_FF
`define MASK_LOSC 8'h00_3F
`define MASK_BGAP 8'h00_7F
`define MASK_XOSC 8'h00_C0
`define MASK_MOSC_CUR 8'h00_03
`define MASK_FLASH 8'h00_01
// Reset values
`define RST_ZERO 8'h00_00
`define RST_BGAP 8'h00_18
// Main oscillator trim waits at its lowest code until boot loads the factory value
`define RST_MOSC 8'h00_00
`define RST_BGAP_OUT 6'h18
`define RST_IDAC_ON 2'h3
`define MASK_BGAP_KEEP 8'h00_40
`define MASK_BGAP_FACT 8'h00_3F
`define TRIM_HI 5
// Oscillator control 2 fields
`define BIT_DBL_DIS 0
`define BIT_EXT_CLK 2
`define BIT_WDT_SRC 3
`define BIT_SLP_EXT 4
// Voltage monitor control fields
`define BIT_PUMP_DIS 7
`define POR_HI 5
`define POR_LO 4
`define BIT_THROTTLE 3
`define LVL_HI 2
`define LVL_LO 0
`define POR_CODE_RSVD 2'h0_3
// Status bits
`define BIT_ST_PUMP 2
`define BIT_ST_LVD 1
`define BIT_ST_PRECISION_POWER_ON_STATE 0
// Bandgap and oscillator fields
`define BIT_AGND_BYP 6
`define LOSC_BIAS_HI 5
`define LOSC_BIAS_LO 4
`define DUTY_HI 7
`define DUTY_LO 6
// Current DAC source codes
`define IDAC_ALWAYS_ON 4'h0_0
`define IDAC_DEC_BASE 2'h0_1
`define IDAC_ACC_BASE 2'h0_2
`define IDAC_RAMP0 4'h0_E
`define IDAC_RAMP1 4'h0_F
`endif

// ### system_trim_monitor.sv
// Port-level assertions for the system trim register bank
`default_nettype none
`include "system_trim_consts.vh"
module system_trim_monitor (
	input wire logic clk_sys_in,
	input wire logic rstn_in,
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic [7:0] rdata_out,
	input wire logic lvd_below_in,
	input wire logic supervisory_mode_in,
	input wire logic external_clock_select_out,
	input wire logic watchdog_clock_internal_out,
	input wire logic fast_clock_enable_out,
	input wire logic sysclk_force_on_out,
	input wire logic pump_enable_out,
	input wire logic [1:0] power_on_trip_level_out,
	input wire logic cpu_speed_reset_out,
	input wire logic [2:0] low_voltage_level_out,
	input wire logic precision_power_on_state_status_valid_out,
	input wire logic flash_bank_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// One domain, so clock and reset are given once
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!rstn_in);
	// Control outputs land two cycles after the write is taken
	chk_clock_select: assert property (wr_in && addr_in == `OFF_OSC_CTRL2 |-> ##2
		external_clock_select_out == $past(wdata_in[2], 2) && watchdog_clock_internal_out == $past(wdata_in[3], 2))
		else $error("clock select bits wrong");
	chk_fast_clock: assert property (wr_in && addr_in == `OFF_OSC_CTRL2 |-> ##2
		fast_clock_enable_out != $past(wdata_in[0], 2) && sysclk_force_on_out == fast_clock_enable_out)
		else $error("fast clock enable wrong");
	chk_pump_write: assert property (wr_in && addr_in == `OFF_VMON_CTRL |-> ##2
		pump_enable_out == !$past(wdata_in[7], 2)) else $error("pump enable wrong");
	chk_trip_fields: assert property (wr_in && addr_in == `OFF_VMON_CTRL |-> ##2
		{power_on_trip_level_out, low_voltage_level_out} == {$past(wdata_in[5:4], 2), $past(wdata_in[2:0], 2)})
		else $error("trip levels wrong");
	// A comparator quiet for six cycles cannot throttle the processor
	chk_throttle_quiet: assert property (!lvd_below_in [*6] |-> !cpu_speed_reset_out)
		else $error("throttle without low voltage");
	chk_status_upper: assert property (rd_in && addr_in == `OFF_VMON_STAT |=> rdata_out[7:3] == 5'h00)
		else $error("status upper bits set");
	chk_precision_power_on_state_level: assert property (precision_power_on_state_status_valid_out |-> power_on_trip_level_out == 2'h3)
		else $error("precision status valid at wrong level");
	chk_trim_hidden: assert property (rd_in && addr_in == `OFF_MOSC_TRIM |=> rdata_out == 8'h00)
		else $error("write-only trim readable");
	// Bank choice is masked while user code runs
	chk_flash_user: assert property (!supervisory_mode_in [*5] |-> !flash_bank_out)
		else $error("bank active in user mode");
endmodule
bind system_trim_config_regs system_trim_monitor system_trim_monitor_i (.*);
`default_nettype wire

// ### system_trim_config_regs_tb.sv
// Self-checking bench for the system trim register bank
`default_nettype none
module system_trim_config_regs_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys_in = 1'h0;
	logic rstn_in, wr_in, rd_in, rd_d, boot_load_in, pump_below_in, lvd_below_in, precision_power_on_state_below_in;
	logic precision_power_on_state_reset_disabled_in, supervisory_mode_in, external_clock_select_out, watchdog_clock_internal_out;
	logic sleep_extend_out, fast_clock_enable_out, sysclk_force_on_out, pump_enable_out, cpu_speed_reset_out;
	logic precision_power_on_state_status_valid_out, analog_ground_bypass_out, flash_bank_out;
	logic [7:0] addr_in, wdata_in, rdata_out, d, boot_mosc_trim_in, boot_losc_trim_in, boot_bgap_trim_in;
	logic [7:0] boot_xosc_trim_in, adc0_cap_trim_value_out, adc1_cap_trim_value_out, main_oscillator_trim_out;
	logic [3:0] decimator_input_in, accumulator_compare_in, k;
	logic [1:0] ramp_compare_output_in, idac_on_out, power_on_trip_level_out, sleep_duty_cycle_out;
	logic [1:0] oscillator_current_trim_out;
	logic [2:0] low_voltage_level_out;
	logic [5:0] low_speed_oscillator_trim_out, bandgap_trim_out;
	logic [7:0] q[$]; // Expected read data, oldest first
	// Address, writable bits, bits visible on outputs; 10 is unmapped
	logic [7:0] ra [13] = '{8'hE2, 8'hE3, 8'hE4, 8'hE5, 8'hE6, 8'hE7, 8'hE8, 8'hE9, 8'hEA, 8'hEB, 8'hEF, 8'hFA, 8'h10};
	logic [7:0] wm [13] = '{8'h1D, 8'hBF, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'h7F, 8'hC0, 8'h03, 8'h01, 8'hFF};
	logic [7:0] om [13] = '{8'h1D, 8'hB7, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'h3F, 8'h7F, 8'hC0, 8'h03, 8'h00, 8'h00};
	int n_fail = 0, compares = 0, i;
	system_trim_config_regs system_trim_config_regs_i (.*);
	always #50 clk_sys_in = ~clk_sys_in;
	task check(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk_sys_in);
		{wr_in, addr_in, wdata_in} <= {1'h1, a, v};
		@(posedge clk_sys_in);
		wr_in <= 1'h0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_sys_in);
		{rd_in, addr_in} <= {1'h1, a};
		q.push_back(e);
		@(posedge clk_sys_in);
		rd_in <= 1'h0;
	endtask
	task settle(input int n);
		repeat (n) @(posedge clk_sys_in);
		@(negedge clk_sys_in);
	endtask
	task close_out;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Output bits laid out like the register they come from
	function automatic logic [7:0] view(input logic [7:0] a);
		case (a)
			8'hE2: view = {3'h0, sleep_extend_out, watchdog_clock_internal_out, external_clock_select_out, 1'h0,
				~fast_clock_enable_out};
			8'hE3: view = {~pump_enable_out, 1'h0, power_on_trip_level_out, 1'h0, low_voltage_level_out};
			8'hE5: view = adc0_cap_trim_value_out;
			8'hE6: view = adc1_cap_trim_value_out;
			8'hE8: view = main_oscillator_trim_out;
			8'hE9: view = {2'h0, low_speed_oscillator_trim_out};
			8'hEA: view = {1'h0, analog_ground_bypass_out, bandgap_trim_out};
			8'hEB: view = {sleep_duty_cycle_out, 6'h00};
			8'hEF: view = {6'h00, oscillator_current_trim_out};
			default: view = 8'h00;
		endcase
	endfunction
	// Expected on/off for one current DAC source code; reserved codes stay off
	function automatic logic on(input logic [3:0] c);
		case (c[3:2])
			2'h0: on = (c == 4'h0);
			2'h1: on = decimator_input_in[c[1:0]];
			2'h2: on = accumulator_compare_in[c[1:0]];
			default: on = c[1] & ramp_compare_output_in[c[0]];
		endcase
	endfunction
	// Read data is checked one cycle after its strobe
	always @(posedge clk_sys_in) begin
		rd_d <= rd_in;
		if (rd_d === 1'h1)
			check(rdata_out, q.pop_front());
	end
	// Hang guard at 10000 cycles, far beyond the few hundred cycles needed
	initial begin
		#1_000_000;
		n_fail++;
		close_out;
	end
	initial begin
		{rstn_in, wr_in, rd_in, boot_load_in, pump_below_in, lvd_below_in, precision_power_on_state_below_in} = '0;
		{precision_power_on_state_reset_disabled_in, supervisory_mode_in, addr_in, wdata_in, decimator_input_in} = '0;
		{accumulator_compare_in, ramp_compare_output_in, boot_mosc_trim_in, boot_losc_trim_in} = '0;
		{boot_bgap_trim_in, boot_xosc_trim_in} = '0;
		d = $urandom(51331);
		repeat (20) @(posedge clk_sys_in);
		rstn_in <= 1'h1;
		settle(4);
		for (i = 0; i < 13; i++)
			rd(ra[i], ra[i] == 8'hEA ? 8'h18 : 8'h00);
		settle(2);
		check(main_oscillator_trim_out, 8'h00);
		check({5'h0, fast_clock_enable_out, sysclk_force_on_out, pump_enable_out}, 8'h07);
		// Random writes keep reserved bits at zero; unmapped and write-only read zero
		for (i = 0; i < 13; i++) begin
			d = $urandom & wm[i];
			wr(ra[i], d);
			rd(ra[i], (ra[i] == 8'hE8 || ra[i] == 8'h10) ? 8'h00 : d);
			settle(1);
			check(view(ra[i]), d & om[i]);
		end
		// Every current DAC source code, the second DAC taking the inverse code
		for (int c = 0; c < 16; c++) begin
			k = c;
			@(posedge clk_sys_in);
			{decimator_input_in, accumulator_compare_in, ramp_compare_output_in} <= $urandom;
			wr(8'hE7, {~k, k});
			settle(4);
			check({6'h0, idac_on_out}, {6'h0, on(~k), on(k)});
		end
		// Comparator states against throttle, precision status and bank gating
		wr(8'hFA, 8'h01);
		for (int c = 0; c < 8; c++) begin
			k = c;
			@(posedge clk_sys_in);
			{pump_below_in, lvd_below_in, precision_power_on_state_below_in} <= k[2:0];
			{precision_power_on_state_reset_disabled_in, supervisory_mode_in} <= {k[2], k[2]};
			wr(8'hE3, {2'h0, k[1], k[1], k[0], 3'h0});
			settle(4);
			rd(8'hE4, {5'h0, k[2:0]});
			check({7'h0, cpu_speed_reset_out}, {7'h0, k[0] & k[1]});
			check({7'h0, precision_power_on_state_status_valid_out}, {7'h0, k[1] & k[2]});
			check({7'h0, flash_bank_out}, {7'h0, k[2]});
		end
		// Boot load replaces factory trims but keeps the bypass bit
		wr(8'hEA, 8'h40);
		@(posedge clk_sys_in);
		{boot_mosc_trim_in, boot_losc_trim_in, boot_bgap_trim_in, boot_xosc_trim_in} <= {$urandom, $urandom};
		settle(1);
		@(posedge clk_sys_in);
		boot_load_in <= 1'h1;
		settle(5);
		rd(8'hE9, boot_losc_trim_in & 8'h3F);
		rd(8'hEA, 8'h40 | boot_bgap_trim_in & 8'h3F);
		rd(8'hEB, boot_xosc_trim_in & 8'hC0);
		check(main_oscillator_trim_out, boot_mosc_trim_in);
		boot_load_in <= 1'h0;
		settle(3);
		close_out;
	end
endmodule
`default_nettype wire
